// ---- logic/mec_pkg.sv ----
// constants for the module enable and timer clock gating block
// Overview of operation
// - one shared 18 kHz clock feeds both timers
// - timer clock passes only while gate bit set
// - reference forced off during shutdown
// - shutdown never alters stored reference bit
// - every enable gated off during shutdown
`default_nettype none

package mec_pkg;

    // ------------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------------
    // system clock rate in hertz
    localparam int unsigned MEC_MCLK_HZ = 100_000_000;
    // shared timer clock rate in hertz
    localparam int unsigned MEC_TIMER_CLK_HZ = 18_000;
    // cycles per half period of the timer clock, rounded down
    localparam int unsigned MEC_TIMER_HALF_CYCLES =
        MEC_MCLK_HZ / (2 * MEC_TIMER_CLK_HZ);

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    // address width seen by the bus slave
    localparam int unsigned MEC_ADDR_W = 12;
    // control register offset
    localparam logic [11:0] MEC_OFF_CTL0 = 12'h000;
    // status register offset
    localparam logic [11:0] MEC_OFF_STAT = 12'h004;
    // control register value after reset
    localparam logic [7:0] MEC_CTL0_RESET = 8'h00;
    // writable bits of the control register, bit 2 reserved
    localparam logic [7:0] MEC_CTL0_WMASK = 8'hFB;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int unsigned MEC_BIT_KEY_SCAN = 7;
    localparam int unsigned MEC_BIT_CODEC = 6;
    localparam int unsigned MEC_BIT_REF_PD = 5;
    localparam int unsigned MEC_BIT_SERIAL = 4;
    localparam int unsigned MEC_BIT_TONE = 3;
    localparam int unsigned MEC_BIT_TIMER_GATE = 1;
    localparam int unsigned MEC_BIT_TIMER_IDLE = 0;

    // ------------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------------
    localparam int unsigned MEC_ST_GATE_ON = 0;
    localparam int unsigned MEC_ST_TIMER_LVL = 1;
    localparam int unsigned MEC_ST_REF_OFF = 2;
    localparam int unsigned MEC_ST_SHUTDOWN = 3;

    // ------------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0] MEC_RESP_OKAY = 2'h0;
    localparam logic [1:0] MEC_RESP_DECERR = 2'h3;

endpackage

`default_nettype wire

// ---- logic/mec_clk_div.sv ----
// divider that makes the shared timer square wave from the system clock
`timescale 1ns/1ps
`default_nettype none

module mec_clk_div
    import mec_pkg::*;
#(
    parameter int unsigned HALF_CYCLES = MEC_TIMER_HALF_CYCLES
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // divided clock level
    output logic div_clk
);

    // ------------------------------------------------------------------
    // half period counter
    // ------------------------------------------------------------------
    localparam int unsigned CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;

    // cycles spent in the current half period
    logic [CW-1:0] cnt;
    // end of a half period
    wire logic half_done = (cnt == CW'(HALF_CYCLES - 1));

    // count and toggle; frozen while the clock enable is low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            div_clk <= 1'b0;
        end
        else if (clk_en)
        begin
            cnt <= half_done ? '0 : cnt + 1'b1;
            if (half_done)
            begin
                div_clk <= ~div_clk;
            end
        end
    end

endmodule // mec_clk_div

`default_nettype wire

// ---- logic/mec_top.sv ----
// module enable register with timer clock gating and reference control
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module mec_top
    import mec_pkg::*;
#(
    parameter int unsigned TIMER_HALF_CYCLES = MEC_TIMER_HALF_CYCLES
)
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    // shutdown indicator from the on-chip sequencer, same clock
    input wire logic shutdown_active,
    // axi4-lite write address
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [MEC_ADDR_W-1:0] s_awaddr,
    input wire logic [2:0] s_awprot,
    // axi4-lite write data
    input wire logic s_wvalid,
    output logic s_wready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    // axi4-lite write response
    output logic s_bvalid,
    input wire logic s_bready,
    output logic [1:0] s_bresp,
    // axi4-lite read address
    input wire logic s_arvalid,
    output logic s_arready,
    input wire logic [MEC_ADDR_W-1:0] s_araddr,
    input wire logic [2:0] s_arprot,
    // axi4-lite read data
    output logic s_rvalid,
    input wire logic s_rready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    // timer count inputs of the microcontroller
    output logic timer_zero_count_input,
    output logic timer_one_count_input,
    // analog reference power down, high means off
    output logic analog_ref_power_down,
    // gated block enables
    output logic key_scan_enable,
    output logic codec_enable,
    output logic serial_port_enable,
    output logic tone_ringer_enable
);

    // ------------------------------------------------------------------
    // address decode helper
    // ------------------------------------------------------------------
    // word compare; the low two bits only select a byte lane
    function automatic logic addr_hit(input logic [MEC_ADDR_W-1:0] a,
                                      input logic [MEC_ADDR_W-1:0] off);
        return a[MEC_ADDR_W-1:2] == off[MEC_ADDR_W-1:2];
    endfunction

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // module_enable_ctl_0 contents
    logic [7:0] module_enable_ctl_0;
    // write address parked until its data arrives
    logic [MEC_ADDR_W-1:0] aw_addr;
    logic aw_held;
    // write data parked until its address arrives
    logic [7:0] w_data;
    logic w_lane0;
    logic w_held;
    // shared timer clock level
    logic shared_clk;

    // ------------------------------------------------------------------
    // shared timer clock source
    // ------------------------------------------------------------------
    // single divider feeds both timers
    mec_clk_div #(
        .HALF_CYCLES(TIMER_HALF_CYCLES)
    ) u_div (
        .mclk(mclk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .div_clk(shared_clk)
    );

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // handshakes on the write address, write data and read address channels
    wire logic aw_hs = s_awvalid & s_awready;
    wire logic w_hs = s_wvalid & s_wready;
    wire logic ar_hs = s_arvalid & s_arready;
    // write commits once both halves are parked and no response waits
    wire logic wr_fire = aw_held & w_held & ~s_bvalid;
    wire logic wr_ctl = addr_hit(aw_addr, MEC_OFF_CTL0);
    wire logic wr_ok = wr_ctl | addr_hit(aw_addr, MEC_OFF_STAT);
    // status is read only, so writing it is accepted and dropped
    wire logic rd_ctl = addr_hit(s_araddr, MEC_OFF_CTL0);
    wire logic rd_stat = addr_hit(s_araddr, MEC_OFF_STAT);

    // ------------------------------------------------------------------
    // gating
    // ------------------------------------------------------------------
    // every enable masked while shut down
    wire logic [7:0] live_ctl =
        shutdown_active ? 8'h00 : module_enable_ctl_0;
    // timer clock passes only when gate bit set
    wire logic gate_on = live_ctl[MEC_BIT_TIMER_GATE];
    // gated timers sit at the idle level bit
    wire logic next_timer =
        gate_on ? shared_clk : module_enable_ctl_0[MEC_BIT_TIMER_IDLE];
    // reference off in shutdown whatever the bit says
    wire logic next_ref_off =
        module_enable_ctl_0[MEC_BIT_REF_PD] | shutdown_active;
    // status word shows what the pins are really doing
    wire logic [31:0] stat_word = {28'h0000000, shutdown_active,
        analog_ref_power_down, timer_zero_count_input, gate_on};
    wire logic [31:0] next_rdata = rd_ctl ? {24'h000000, module_enable_ctl_0}
        : (rd_stat ? stat_word : 32'h00000000);

    // ------------------------------------------------------------------
    // write channels
    // ------------------------------------------------------------------
    // park address and data separately; either may come first
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            s_awready <= 1'b1;
            w_held <= 1'b0;
            w_data <= 8'h00;
            w_lane0 <= 1'b0;
            s_wready <= 1'b1;
            s_bvalid <= 1'b0;
            s_bresp <= MEC_RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (aw_hs)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_awaddr;
                s_awready <= 1'b0;
            end
            if (w_hs)
            begin
                w_held <= 1'b1;
                w_data <= s_wdata[7:0];
                w_lane0 <= s_wstrb[0];
                s_wready <= 1'b0;
            end
            // response once both halves are in
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_ok ? MEC_RESP_OKAY : MEC_RESP_DECERR;
            end
            // reopen both channels when the response is taken
            else if (s_bvalid && s_bready)
            begin
                s_bvalid <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    // only a bus write changes the stored bits
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            module_enable_ctl_0 <= MEC_CTL0_RESET;
        end
        else if (clk_en && wr_fire && wr_ctl && w_lane0)
        begin
            module_enable_ctl_0 <= w_data & MEC_CTL0_WMASK;
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    // one read at a time; unmapped words answer decode error
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= MEC_RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (ar_hs)
            begin
                s_arready <= 1'b0;
                s_rvalid <= 1'b1;
                s_rdata <= next_rdata;
                s_rresp <= (rd_ctl | rd_stat) ? MEC_RESP_OKAY
                                              : MEC_RESP_DECERR;
            end
            else if (s_rvalid && s_rready)
            begin
                s_rvalid <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------
    // registered so the pins never glitch on decode changes
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_zero_count_input <= 1'b0;
            timer_one_count_input <= 1'b0;
            analog_ref_power_down <= 1'b0;
            key_scan_enable <= 1'b0;
            codec_enable <= 1'b0;
            serial_port_enable <= 1'b0;
            tone_ringer_enable <= 1'b0;
        end
        else if (clk_en)
        begin
            // both timers take the same level
            timer_zero_count_input <= next_timer;
            timer_one_count_input <= next_timer;
            analog_ref_power_down <= next_ref_off;
            key_scan_enable <= live_ctl[MEC_BIT_KEY_SCAN];
            codec_enable <= live_ctl[MEC_BIT_CODEC];
            serial_port_enable <= live_ctl[MEC_BIT_SERIAL];
            tone_ringer_enable <= live_ctl[MEC_BIT_TONE];
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_timers_shared: assert property (
        @(posedge mclk) disable iff (!rst_n)
        timer_zero_count_input == timer_one_count_input)
        else $error("timer inputs differ");

    a_timer_gate_pass: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && gate_on) |=> (timer_zero_count_input == $past(shared_clk)))
        else $error("enabled timer input does not follow shared clock");

    a_timer_idle_level: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && !gate_on) |=>
            (timer_one_count_input == $past(module_enable_ctl_0[0])))
        else $error("gated timer input not at idle level");

    a_ref_off_shut: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && shutdown_active) |=> analog_ref_power_down)
        else $error("reference left on in shutdown");

    a_ref_bit_kept: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ($rose(shutdown_active) && !wr_fire) |=> $stable(module_enable_ctl_0))
        else $error("shutdown changed stored control bits");

    a_enables_shut: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && shutdown_active) |=>
            !(key_scan_enable | codec_enable | serial_port_enable
              | tone_ringer_enable))
        else $error("block enabled during shutdown");

    a_enable_restore: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (clk_en && !shutdown_active) |=>
            (codec_enable == $past(module_enable_ctl_0[6])))
        else $error("enable not restored after shutdown");

endmodule // mec_top

`default_nettype wire

// ---- tb/module_enable_clock_gating_tb_top.sv ----
// self-checking bench for the module enable and timer gating block
`timescale 1ns/1ps
`default_nettype none

module module_enable_clock_gating_tb_top import mec_pkg::*;;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    // short half period keeps the run brief
    localparam int unsigned HALF = 4;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic shutdown_active = 1'b0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0;
    logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
    logic [31:0] s_wdata = 32'h0000_0000;
    logic [3:0] s_wstrb = 4'hF;
    wire logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    wire logic [1:0] s_bresp, s_rresp;
    wire logic [31:0] s_rdata;
    wire logic tmr_zero, tmr_one, ref_pd, key, codec, serial, tone;
    // gathered outputs: key codec ref serial tone timer0 timer1
    wire logic [6:0] pins;
    assign pins = {key, codec, ref_pd, serial, tone, tmr_zero, tmr_one};
    int n_fail = 0;
    int tests_run = 0;
    logic [1:0] rsp;
    logic [31:0] rd;
    // table rows: value written, value read back
    logic [7:0] row_wr [6] = '{8'h00, 8'hFF, 8'h01, 8'h22, 8'hD8, 8'h03};
    logic [7:0] row_rd [6] = '{8'h00, 8'hFB, 8'h01, 8'h22, 8'hD8, 8'h03};

    always #5 mclk = ~mclk;

    mec_top #(.TIMER_HALF_CYCLES(HALF)) DUT (
        .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1),
        .shutdown_active(shutdown_active),
        .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_awaddr(s_awaddr), .s_awprot(3'h0),
        .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
        .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_araddr(s_araddr), .s_arprot(3'h0),
        .s_rvalid(s_rvalid), .s_rready(s_rready),
        .s_rdata(s_rdata), .s_rresp(s_rresp),
        .timer_zero_count_input(tmr_zero), .timer_one_count_input(tmr_one),
        .analog_ref_power_down(ref_pd), .key_scan_enable(key),
        .codec_enable(codec), .serial_port_enable(serial),
        .tone_ringer_enable(tone)
    );

    // ------------------------------------------------------------------
    // compare and bus tasks
    // ------------------------------------------------------------------
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_data({30'h0, got}, {30'h0, exp});
    endtask
    task automatic cmp_pins(input logic [6:0] got, input logic [6:0] exp);
        cmp_data({25'h0, got}, {25'h0, exp});
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] st, output logic [1:0] r);
        @(posedge mclk);
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= st;
        s_bready <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (s_awvalid && s_awready === 1'b1) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready === 1'b1) s_wvalid <= 1'b0;
            if (s_bvalid === 1'b1)
            begin
                r = s_bresp;
                s_bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rdw(input logic [11:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge mclk);
        s_arvalid <= 1'b1;
        s_araddr <= a;
        s_rready <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (s_arvalid && s_arready === 1'b1) s_arvalid <= 1'b0;
            if (s_rvalid === 1'b1)
            begin
                d = s_rdata;
                r = s_rresp;
                s_rready <= 1'b0;
                break;
            end
        end
    endtask

    // expected outputs from control value and shutdown state
    function automatic logic [6:0] exp_pins(input logic [7:0] c,
                                            input logic s);
        logic lv;
        lv = c[MEC_BIT_TIMER_IDLE];
        return {c[MEC_BIT_KEY_SCAN] & ~s, c[MEC_BIT_CODEC] & ~s,
                c[MEC_BIT_REF_PD] | s, c[MEC_BIT_SERIAL] & ~s,
                c[MEC_BIT_TONE] & ~s, lv, lv};
    endfunction

    // one full half period of the shared clock, both timers alike
    task automatic check_toggle();
        int n;
        logic lv;
        lv = tmr_zero;
        for (n = 0; n < 20 && tmr_zero === lv; n++) @(posedge mclk);
        lv = tmr_zero;
        n = 0;
        while (n < 20 && tmr_zero === lv)
        begin
            cmp_data({31'h0, tmr_one}, {31'h0, tmr_zero});
            @(posedge mclk);
            n++;
        end
        cmp_data(n, HALF);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // watchdog: whole run is a few hundred cycles
    // ------------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        cmp_pins(pins, 7'h00);
        rdw(MEC_OFF_CTL0, rd, rsp);
        cmp_data(rd, {24'h0, MEC_CTL0_RESET});
        $display("test reset done");
        // table rows; gate on means the timers run, so mask them
        for (int i = 0; i < 6; i++)
        begin
            wr(MEC_OFF_CTL0, {24'h0, row_wr[i]}, 4'hF, rsp);
            cmp_resp(rsp, MEC_RESP_OKAY);
            rdw(MEC_OFF_CTL0, rd, rsp);
            cmp_data(rd, {24'h0, row_rd[i]});
            repeat (10) @(posedge mclk);
            if (row_wr[i][MEC_BIT_TIMER_GATE])
            begin
                cmp_pins(pins & 7'h7C, exp_pins(row_rd[i], 1'b0) & 7'h7C);
                check_toggle();
            end
            else
                cmp_pins(pins, exp_pins(row_rd[i], 1'b0));
        end
        $display("test table done");
        // shutdown gates everything and forces the reference off
        wr(MEC_OFF_CTL0, 32'h0000_00DA, 4'hF, rsp);
        repeat (2) @(posedge mclk);
        shutdown_active <= 1'b1;
        repeat (3) @(posedge mclk);
        cmp_pins(pins, exp_pins(8'hDA, 1'b1));
        rdw(MEC_OFF_CTL0, rd, rsp);
        cmp_data(rd, 32'h0000_00DA);
        rdw(MEC_OFF_STAT, rd, rsp);
        cmp_data(rd, 32'h0000_000C);
        shutdown_active <= 1'b0;
        repeat (3) @(posedge mclk);
        cmp_pins(pins & 7'h7C, exp_pins(8'hDA, 1'b0) & 7'h7C);
        check_toggle();
        $display("test shutdown done");
        // unmapped place, empty strobe, upper bytes ignored
        wr(12'h008, 32'h0000_00FF, 4'hF, rsp);
        cmp_resp(rsp, MEC_RESP_DECERR);
        rdw(12'h008, rd, rsp);
        cmp_resp(rsp, MEC_RESP_DECERR);
        cmp_data(rd, 32'h0000_0000);
        wr(MEC_OFF_CTL0, 32'h0000_0000, 4'h0, rsp);
        cmp_resp(rsp, MEC_RESP_OKAY);
        // status is read only: write taken, nothing stored
        wr(MEC_OFF_STAT, 32'h0000_00FF, 4'hF, rsp);
        cmp_resp(rsp, MEC_RESP_OKAY);
        rdw(MEC_OFF_CTL0, rd, rsp);
        cmp_data(rd, 32'h0000_00DA);
        wr(MEC_OFF_CTL0, 32'hFFFF_FF00, 4'hF, rsp);
        rdw(MEC_OFF_CTL0, rd, rsp);
        cmp_data(rd, 32'h0000_0000);
        $display("test refused done");
        // second reset in mid-run clears all outputs
        wr(MEC_OFF_CTL0, 32'h0000_00F9, 4'hF, rsp);
        repeat (2) @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        cmp_pins(pins, 7'h00);
        rst_n <= 1'b1;
        rdw(MEC_OFF_CTL0, rd, rsp);
        cmp_data(rd, {24'h0, MEC_CTL0_RESET});
        $display("test rereset done");
        wrap_up();
    end
endmodule // module_enable_clock_gating_tb_top

`default_nettype wire
